// ==== core/fm_consts.svh ====
// Constants for the fault monitor: register offsets, status bit positions,
// reset values and thermal comparator levels.
// Assumes inclusion by bare name from files under core/.
`ifndef FM_CONSTS_SVH
`define FM_CONSTS_SVH

// Register offsets on the serial register port
`define FM_ADDR_FAULT_STATUS 8'h0C
`define FM_ADDR_FAULT_CONFIG 8'h0D
`define FM_ADDR_WARN_THR 8'h10
`define FM_ADDR_SHUT_THR 8'h11

// Bit positions inside fault_status and fault_config
`define FM_BIT_SUPPLY 0
`define FM_BIT_ILLUM 1
`define FM_BIT_MIRROR 2
`define FM_BIT_POWER_ON 3
`define FM_BIT_IN_WARN 4
`define FM_BIT_IN_SHUT 5
`define FM_BIT_OT_WARN 6
`define FM_BIT_OT_SHUT 7

// Threshold field is five bits wide, upper bits read as zero
`define FM_THR_MSB 4

// Reset values
`define FM_RST_STATUS 8'h00
`define FM_RST_CONFIG 8'hFF
`define FM_RST_WARN_THR 8'h10
`define FM_RST_SHUT_THR 8'h08
`define FM_RST_RDATA 8'h00

// Die temperature levels in degrees C: set level and release level
`define FM_TEMP_WARN_SET 8'h78
`define FM_TEMP_WARN_CLR 8'h6E
`define FM_TEMP_SHUT_SET 8'h96
`define FM_TEMP_SHUT_CLR 8'h87

`endif

// ==== core/fm_pkg.sv ====
// Types shared by the fault monitor.
// Assumes fm_consts.svh holds all numeric constants.
package fm_pkg;
   typedef logic [7:0] fm_byte_t;
   typedef logic [7:0] fm_addr_t;
   typedef logic [4:0] fm_code_t;

   // Power state, one-hot
   typedef enum logic [1:0] {
      FM_ST_RUN = 2'b01,
      FM_ST_SHUT = 2'b10
   } fm_state_e;
endpackage

// ==== core/fm_fault_monitor.sv ====
// Fault monitor: latches block, input-voltage and thermal faults into
// fault_status, raises the interrupt line and forces shutdown.
// Assumes an upstream serial port decoder gives one-cycle read and write
// strobes with address and data, all synchronous to clk_i.
`timescale 1ns/1ps
`include "fm_consts.svh"

module fm_fault_monitor (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Register port
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire fm_pkg::fm_addr_t reg_addr_i,
   input wire fm_pkg::fm_byte_t reg_wdata_i,
   output fm_pkg::fm_byte_t reg_rdata_o,
   output logic reg_rvalid_o,
   // Block fault sources
   input wire logic supply_fault_i,
   input wire logic illum_fault_i,
   input wire logic mirror_supply_fault_i,
   input wire logic power_on_request_pin_i,
   // Measured input voltage, same code scale as the thresholds
   input wire fm_pkg::fm_code_t vin_code_i,
   // Die temperature in degrees C
   input wire fm_pkg::fm_byte_t die_temp_i,
   // Fault outputs
   output logic irq_o,
   output logic shutdown_o,
   output logic input_low_warning_o,
   output logic overheat_warning_o
);
   import fm_pkg::*;

   // Below-threshold comparator; once active it holds until the code
   // climbs above the threshold, one code step of hysteresis
   function automatic logic below_hyst(input logic act, input fm_code_t v,
                                       input fm_code_t thr);
      below_hyst = act ? (v <= thr) : (v < thr);
   endfunction

   // Above-threshold comparator with separate set and release levels
   function automatic logic above_hyst(input logic act, input fm_byte_t t,
                                       input fm_byte_t set_lvl,
                                       input fm_byte_t clr_lvl);
      above_hyst = act ? (t > clr_lvl) : (t >= set_lvl);
   endfunction

   fm_byte_t fault_status;
   fm_byte_t fault_config;
   fm_byte_t input_warn_threshold;
   fm_byte_t input_shutdown_threshold;
   fm_byte_t prev_cond;
   fm_state_e state;
   logic in_warn_act;
   logic in_shut_act;
   logic ot_warn_act;
   logic ot_shut_act;

   // Address decode
   wire logic sel_status = (reg_addr_i == `FM_ADDR_FAULT_STATUS);
   wire logic sel_config = (reg_addr_i == `FM_ADDR_FAULT_CONFIG);
   wire logic sel_warn = (reg_addr_i == `FM_ADDR_WARN_THR);
   wire logic sel_shut = (reg_addr_i == `FM_ADDR_SHUT_THR);
   wire logic status_rd = reg_rd_i && sel_status;

   // Threshold fields, only the low five bits are stored
   wire fm_code_t warn_thr = input_warn_threshold[`FM_THR_MSB:0];
   wire fm_code_t shut_thr = input_shutdown_threshold[`FM_THR_MSB:0];

   // Comparator next values
   wire logic next_in_warn = below_hyst(in_warn_act, vin_code_i, warn_thr);
   wire logic next_in_shut = below_hyst(in_shut_act, vin_code_i, shut_thr);
   wire logic next_ot_warn = above_hyst(ot_warn_act, die_temp_i,
                                        `FM_TEMP_WARN_SET,
                                        `FM_TEMP_WARN_CLR);
   wire logic next_ot_shut = above_hyst(ot_shut_act, die_temp_i,
                                        `FM_TEMP_SHUT_SET,
                                        `FM_TEMP_SHUT_CLR);

   // Fault condition vector in fault_status bit order
   wire fm_byte_t cond = {ot_shut_act, ot_warn_act, in_shut_act,
                          in_warn_act, power_on_request_pin_i,
                          mirror_supply_fault_i, illum_fault_i,
                          supply_fault_i};

   // A fault counts once per onset, so a lasting fault cannot keep
   // re-raising the interrupt right after software has read it
   wire fm_byte_t rise = cond & ~prev_cond;
   wire fm_byte_t report = rise & fault_config;

   // Read clears what was seen; a new event in the same cycle wins
   wire fm_byte_t clr_mask = status_rd ? fault_status : 8'h00;
   wire fm_byte_t next_status = (fault_status & ~clr_mask) | report;

   // Severe faults ignore fault_config: masking must never defeat safety
   wire logic shut_req = in_shut_act || ot_shut_act;
   wire fm_state_e next_state = shut_req ? FM_ST_SHUT : state;

   // Read data mux; unmapped offsets read as zero
   wire fm_byte_t next_rdata =
      sel_status ? fault_status :
      sel_config ? fault_config :
      sel_warn ? {3'h0, warn_thr} :
      sel_shut ? {3'h0, shut_thr} : 8'h00;

   // Software-written registers
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         fault_config <= `FM_RST_CONFIG;
         input_warn_threshold <= `FM_RST_WARN_THR;
         input_shutdown_threshold <= `FM_RST_SHUT_THR;
      end else if (reg_wr_i) begin
         if (sel_config) begin
            fault_config <= reg_wdata_i;
         end
         if (sel_warn) begin
            input_warn_threshold <= {3'h0, reg_wdata_i[`FM_THR_MSB:0]};
         end
         if (sel_shut) begin
            input_shutdown_threshold <= {3'h0,
                                         reg_wdata_i[`FM_THR_MSB:0]};
         end
      end
   end

   // Comparator states and onset detection
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         in_warn_act <= 1'b0;
         in_shut_act <= 1'b0;
         ot_warn_act <= 1'b0;
         ot_shut_act <= 1'b0;
         prev_cond <= 8'h00;
      end else begin
         in_warn_act <= next_in_warn;
         in_shut_act <= next_in_shut;
         ot_warn_act <= next_ot_warn;
         ot_shut_act <= next_ot_shut;
         prev_cond <= cond;
      end
   end

   // Sticky status and power state; shutdown holds until device reset
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         fault_status <= `FM_RST_STATUS;
         state <= FM_ST_RUN;
      end else begin
         fault_status <= next_status;
         state <= next_state;
      end
   end

   // Registered read answer, one cycle after the strobe
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reg_rdata_o <= `FM_RST_RDATA;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
         end
      end
   end

   // Outputs
   assign irq_o = |fault_status;
   assign shutdown_o = (state == FM_ST_SHUT);
   assign input_low_warning_o = in_warn_act;
   assign overheat_warning_o = ot_warn_act;

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   sequence seq_status_read;
      status_rd && (report == 8'h00);
   endsequence

   sequence seq_vin_below_shut;
      vin_code_i < shut_thr;
   endsequence

   sequence seq_thr_read;
      reg_rd_i && (sel_warn || sel_shut);
   endsequence

   AST_STATUS_LATCH: assert property (
      (report != 8'h00) |=> ((fault_status & $past(report)) == $past(report)))
      else $error("reported fault not latched in status");

   AST_IRQ_RAISE: assert property (
      (report != 8'h00) |=> irq_o)
      else $error("interrupt not raised on fault");

   AST_CONFIG_GATE: assert property (
      ((fault_status & ~$past(fault_status) & ~$past(report)) == 8'h00))
      else $error("status bit set without enabled onset");

   AST_POWER_ON_FLAG: assert property (
      $rose(power_on_request_pin_i) && fault_config[`FM_BIT_POWER_ON]
      |=> fault_status[`FM_BIT_POWER_ON])
      else $error("power-on event flag not set");

   AST_THR_UPPER_ZERO: assert property (
      seq_thr_read |=> reg_rvalid_o && (reg_rdata_o[7:5] == 3'h0))
      else $error("threshold upper bits not zero");

   AST_IN_SHUTDOWN: assert property (
      seq_vin_below_shut |-> ##2 shutdown_o)
      else $error("no shutdown below input threshold");

   AST_IN_WARN: assert property (
      (vin_code_i < warn_thr) |=> input_low_warning_o)
      else $error("no warning below input threshold");

   AST_OT_WARN_RECORD: assert property (
      (die_temp_i >= `FM_TEMP_WARN_SET) && !ot_warn_act
      && fault_config[`FM_BIT_OT_WARN]
      |-> ##2 fault_status[`FM_BIT_OT_WARN])
      else $error("overheat warning not recorded");

   AST_OT_SHUTDOWN: assert property (
      (die_temp_i >= `FM_TEMP_SHUT_SET) |-> ##2 shutdown_o)
      else $error("no shutdown at thermal shutdown level");

   AST_OT_HYST_HOLD: assert property (
      ot_warn_act && (die_temp_i > `FM_TEMP_WARN_CLR) |=> ot_warn_act)
      else $error("overheat warning released inside hysteresis");

   AST_READ_CLEARS: assert property (
      seq_status_read |=> (fault_status == 8'h00) && !irq_o)
      else $error("status read did not clear or irq stuck");

   // Block fault onsets that fault_config lets through
   sequence seq_supply_onset;
      $rose(supply_fault_i) && fault_config[`FM_BIT_SUPPLY];
   endsequence

   sequence seq_illum_onset;
      $rose(illum_fault_i) && fault_config[`FM_BIT_ILLUM];
   endsequence

   sequence seq_mirror_onset;
      $rose(mirror_supply_fault_i) && fault_config[`FM_BIT_MIRROR];
   endsequence

   AST_SUPPLY_RECORD: assert property (
      seq_supply_onset |=> fault_status[`FM_BIT_SUPPLY])
      else $error("supply fault not recorded");

   AST_ILLUM_RECORD: assert property (
      seq_illum_onset |=> fault_status[`FM_BIT_ILLUM])
      else $error("illumination fault not recorded");

   AST_MIRROR_RECORD: assert property (
      seq_mirror_onset |=> fault_status[`FM_BIT_MIRROR])
      else $error("mirror supply fault not recorded");

   AST_IN_WARN_RECORD: assert property (
      $rose(input_low_warning_o) && fault_config[`FM_BIT_IN_WARN]
      |=> fault_status[`FM_BIT_IN_WARN])
      else $error("input low warning not recorded");

   AST_IN_SHUT_RECORD: assert property (
      $rose(in_shut_act) && fault_config[`FM_BIT_IN_SHUT]
      |=> fault_status[`FM_BIT_IN_SHUT])
      else $error("input low shutdown not recorded");

   AST_OT_SHUT_RECORD: assert property (
      $rose(ot_shut_act) && fault_config[`FM_BIT_OT_SHUT]
      |=> fault_status[`FM_BIT_OT_SHUT])
      else $error("overheat shutdown not recorded");

   AST_SHUT_STICKY: assert property (
      shutdown_o |=> shutdown_o)
      else $error("shutdown released before reset");

   AST_OT_SHUT_HYST: assert property (
      ot_shut_act && (die_temp_i > `FM_TEMP_SHUT_CLR) |=> ot_shut_act)
      else $error("overheat shutdown released inside hysteresis");

   AST_STATUS_HOLD: assert property (
      !status_rd |=> ((fault_status & $past(fault_status)) ==
                      $past(fault_status)))
      else $error("status bit lost without a read");

   AST_STATUS_READBACK: assert property (
      status_rd |=> reg_rvalid_o && (reg_rdata_o == $past(fault_status)))
      else $error("status read returned wrong value");

   AST_CONFIG_WRITE: assert property (
      reg_wr_i && sel_config |=> (fault_config == $past(reg_wdata_i)))
      else $error("fault_config write not taken");

   AST_WARN_THR_WRITE: assert property (
      reg_wr_i && sel_warn
      |=> ({3'h0, warn_thr} == ($past(reg_wdata_i) & 8'h1F)))
      else $error("warning threshold write not taken");

   AST_SHUT_THR_WRITE: assert property (
      reg_wr_i && sel_shut
      |=> ({3'h0, shut_thr} == ($past(reg_wdata_i) & 8'h1F)))
      else $error("shutdown threshold write not taken");

   AST_RVALID_PULSE: assert property (
      1'b1 |=> (reg_rvalid_o == $past(reg_rd_i)))
      else $error("read answer not one cycle after strobe");

endmodule // fm_fault_monitor

// ==== verification/fm_host_model.sv ====
// Host controller model: issues register strobes toward the fault monitor.
// Assumes fm_pkg is compiled first and clk_i is the device clock.
`timescale 1ns/1ps
`include "fm_consts.svh"
module fm_host_model (
   // Clock
   input wire logic clk_i,
   // Register strobes toward the device
   output logic reg_wr_o,
   output logic reg_rd_o,
   output fm_pkg::fm_addr_t reg_addr_o,
   output fm_pkg::fm_byte_t reg_wdata_o
);
   import fm_pkg::*;
   initial begin
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
   end
   // One strobe per access; released lines show the inverse, not stale data
   task automatic access(input logic wr, input fm_addr_t a, input fm_byte_t d);
      @(negedge clk_i);
      reg_wr_o = wr;
      reg_rd_o = !wr;
      reg_addr_o = a;
      reg_wdata_o = d;
      @(negedge clk_i);
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = ~a;
      reg_wdata_o = ~d;
   endtask
   // Warning level is kept above the shutdown level so warnings come first
   task automatic set_thr(input fm_byte_t w, input fm_byte_t s);
      if (w[4:0] <= s[4:0]) w[4:0] = s[4:0] + 5'h01;
      access(1'b1, `FM_ADDR_WARN_THR, w);
      access(1'b1, `FM_ADDR_SHUT_THR, s);
   endtask
endmodule // fm_host_model

// ==== verification/fault_monitor_irq_tb_top.sv ====
// Testbench for the fault monitor: block, voltage and thermal faults.
// Assumes fm_pkg is compiled and fm_consts.svh is on the include path.
`timescale 1ns/1ps
`include "fm_consts.svh"
module fault_monitor_irq_tb_top;
   import fm_pkg::*;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic reg_wr, reg_rd, rvalid, irq, shut, in_warn, ot_warn;
   logic sup = 1'b0, ill = 1'b0, mir = 1'b0, pin = 1'b0;
   fm_addr_t reg_addr;
   fm_byte_t wdata, rdata, t = 8'h19;
   fm_byte_t rnd;
   fm_code_t vin = 5'h1F;
   fm_byte_t exp_q[$];
   int failures = 0, samples_checked = 0, cycles = 0, seed = 32'hd2dd;
   always #12.5 clk_i = ~clk_i;
   fm_host_model u_host (.clk_i(clk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
      .reg_addr_o(reg_addr), .reg_wdata_o(wdata));
   fm_fault_monitor u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr),
      .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
      .supply_fault_i(sup), .illum_fault_i(ill), .mirror_supply_fault_i(mir),
      .power_on_request_pin_i(pin), .vin_code_i(vin), .die_temp_i(t),
      .irq_o(irq), .shutdown_o(shut), .input_low_warning_o(in_warn),
      .overheat_warning_o(ot_warn));
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic chk8(input fm_byte_t got, input fm_byte_t exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: read %h, want %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: flag %b, want %b", $time, got, exp);
      end
   endtask
   // Reads note their expected byte; the watcher below does the compare
   task automatic rd(input fm_addr_t a, input fm_byte_t e);
      exp_q.push_back(e);
      u_host.access(1'b0, a, 8'h00);
      cyc(1);
   endtask
   task automatic print_verdict;
      if (exp_q.size() != 0) begin
         failures++;
         $display("unexpected at %0t: read answers missing", $time);
      end
      $display("checked %0d, failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Watcher: a read answer with no note pending counts as a mismatch
   always @(negedge clk_i) begin
      if (rvalid === 1'b1) begin
         if (exp_q.size() == 0) begin
            failures++;
            $display("unexpected at %0t: read answer with no note", $time);
         end else begin
            chk8(rdata, exp_q.pop_front());
         end
      end
   end
   // Cycle ceiling far above the expected run of about 115 cycles
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         failures++;
         $display("unexpected at %0t: cycle limit reached", $time);
         print_verdict;
      end
   end
   // Main sequence
   initial begin
      cyc(5);
      reset_n_i = 1'b1;
      rd(`FM_ADDR_FAULT_CONFIG, 8'hFF);
      rd(`FM_ADDR_FAULT_STATUS, 8'h00);
      rd(8'h20, 8'h00);
      u_host.access(1'b1, `FM_ADDR_FAULT_STATUS, 8'hFF);
      rd(`FM_ADDR_FAULT_STATUS, 8'h00);
      // Random upper bits must be dropped by the five-bit fields
      rnd = 8'($random(seed));
      u_host.set_thr({rnd[7:5], 5'h14}, {rnd[2:0], 5'h0C});
      rd(`FM_ADDR_WARN_THR, 8'h14);
      rd(`FM_ADDR_SHUT_THR, 8'h0C);
      // Onset on the very edge of a status read: the new event survives
      exp_q.push_back(8'h00);
      fork
         u_host.access(1'b0, `FM_ADDR_FAULT_STATUS, 8'h00);
         begin
            @(negedge clk_i);
            sup = 1'b1;
         end
      join
      cyc(1);
      chk1(irq, 1'b1);
      rd(`FM_ADDR_FAULT_STATUS, 8'h01);
      sup = 1'b0;
      cyc(1);
      // Each block source in turn, the previous one falling meanwhile
      for (int b = 0; b < 4; b++) begin
         {pin, mir, ill, sup} = 4'h1 << b;
         cyc(2);
         chk1(irq, 1'b1);
         rd(`FM_ADDR_FAULT_STATUS, 8'h01 << b);
         chk1(irq, 1'b0);
         rd(`FM_ADDR_FAULT_STATUS, 8'h00);
      end
      {pin, mir, ill, sup} = 4'h0;
      u_host.access(1'b1, `FM_ADDR_FAULT_CONFIG, 8'hFE);
      sup = 1'b1;
      cyc(2);
      chk1(irq, 1'b0);
      rd(`FM_ADDR_FAULT_STATUS, 8'h00);
      u_host.access(1'b1, `FM_ADDR_FAULT_CONFIG, 8'hFF);
      // Input voltage between, then below, the two thresholds
      vin = 5'h13;
      cyc(3);
      chk1(in_warn, 1'b1);
      rd(`FM_ADDR_FAULT_STATUS, 8'h10);
      vin = 5'h0B;
      cyc(3);
      chk1(shut, 1'b1);
      rd(`FM_ADDR_FAULT_STATUS, 8'h20);
      vin = 5'h1F;
      sup = 1'b0;
      reset_n_i = 1'b0;
      cyc(2);
      reset_n_i = 1'b1;
      cyc(1);
      // Thermal levels with the release band in between
      t = 8'h78;
      cyc(3);
      chk1(ot_warn, 1'b1);
      rd(`FM_ADDR_FAULT_STATUS, 8'h40);
      t = 8'h73;
      cyc(3);
      chk1(ot_warn, 1'b1);
      t = 8'h6E;
      cyc(3);
      chk1(ot_warn, 1'b0);
      t = 8'h96;
      cyc(3);
      chk1(shut, 1'b1);
      rd(`FM_ADDR_FAULT_STATUS, 8'hC0);
      t = 8'h19;
      cyc(3);
      chk1(shut, 1'b1);
      print_verdict;
   end
endmodule // fault_monitor_irq_tb_top
